// ---- core/aux_mon_pkg.sv ----
// Constants and types shared by the auxiliary voltage monitor.
package aux_mon_pkg;

  // ----------------------------------------------------------------
  // Command codes of the auxiliary monitor registers.
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_OV_LIMIT = 8'hf5;
  localparam logic [7:0] CODE_UV_LIMIT = 8'hf6;
  localparam logic [7:0] CODE_MEAS = 8'hf7;
  localparam logic [7:0] CODE_OV_RESP = 8'hf8;

  // ----------------------------------------------------------------
  // Values after reset.
  // ----------------------------------------------------------------
  localparam logic [15:0] OV_LIMIT_RST = 16'hc266;
  localparam logic [15:0] UV_LIMIT_RST = 16'hb0cc;
  localparam logic [15:0] MEAS_RST = 16'h0000;
  localparam logic [7:0] OV_RESP_RST = 8'hbf;

  // ----------------------------------------------------------------
  // Linear-11 field positions and fixed-point layout.
  // ----------------------------------------------------------------
  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 11;
  localparam int MANT_MSB = 10;
  localparam int FIX_W = 44;
  localparam logic signed [5:0] FIX_FRAC = 6'sd16;
  // Compared values carry a factor of twenty so 90/95/110 % stay integral.
  localparam int CMP_W = 49;
  localparam logic [CMP_W-1:0] SCALE_FULL = 49'd20;
  localparam logic [CMP_W-1:0] SCALE_OV_WARN = 49'd18;
  localparam logic [CMP_W-1:0] SCALE_OV_HYST = 49'd19;
  localparam logic [CMP_W-1:0] SCALE_UV_WARN = 49'd22;

  // ----------------------------------------------------------------
  // Response byte fields and codes.
  // ----------------------------------------------------------------
  localparam int RESP_MODE_LSB = 6;
  localparam int RESP_RETRY_LSB = 3;
  localparam logic [1:0] MODE_IGNORE = 2'b00;
  localparam logic [1:0] MODE_UNUSED = 2'b01;
  localparam logic [1:0] MODE_RETRY = 2'b10;
  localparam logic [1:0] MODE_HOLD = 2'b11;
  localparam logic [2:0] RETRY_NONE = 3'b000;
  localparam logic [2:0] RETRY_CONT = 3'b111;

  // ----------------------------------------------------------------
  // Timing: retry unit of 35 ms at a 125 MHz clock.
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 125000;
  localparam int RETRY_UNIT_MS = 35;
  localparam int RETRY_UNIT_CYCLES = RETRY_UNIT_MS * CLK_KHZ;
  localparam int PRESCALE_W = 23;

  // Overvoltage response states.
  typedef enum logic [2:0] {
    ST_ON = 3'b000,
    ST_LATCHED = 3'b001,
    ST_HOLD = 3'b010,
    ST_WAIT_LOW = 3'b011,
    ST_WAIT_DELAY = 3'b100
  } ov_state_e;

endpackage

// ---- core/retry_timer_if.sv ----
// Handshake between the response logic and the retry interval timer.
`timescale 1ns/1ps
interface retry_timer_if;
  logic start;       // One-cycle pulse that starts an interval.
  logic cancel;      // Level that aborts a running interval.
  logic [2:0] delay; // Interval length in units, minus one.
  logic done;        // One-cycle pulse at the end of an interval.
  modport ctrl (output start, output cancel, output delay, input done);
  modport timer (input start, input cancel, input delay, output done);
endinterface

// ---- core/lin11_to_fixed.sv ----
// Linear-11 word to unsigned fixed point with sixteen fraction bits.
`timescale 1ns/1ps
module lin11_to_fixed
  import aux_mon_pkg::*;
(
  input wire logic [15:0] word,
  output logic [FIX_W-1:0] value
);

  // Exponent plus the fraction width gives a shift of 0 to 31.
  logic signed [5:0] shift_s;
  assign shift_s = {word[EXP_MSB], word[EXP_MSB:EXP_LSB]} + FIX_FRAC;

  // Negative mantissas clamp to zero; the monitored range is positive.
  assign value = word[MANT_MSB] ? '0 :
    ({34'h0, word[MANT_MSB-1:0]} << shift_s[4:0]);

endmodule

// ---- core/retry_timer.sv ----
// Interval timer that counts whole retry units of 35 ms.
`timescale 1ns/1ps
module retry_timer
  import aux_mon_pkg::*;
#(
  parameter int UNIT_CYCLES = RETRY_UNIT_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  retry_timer_if.timer tmr
);

  // ----------------------------------------------------------------
  // Prescaler and unit counter.
  // ----------------------------------------------------------------
  logic [PRESCALE_W-1:0] pre_q;  // Cycles within the current unit.
  logic [3:0] units_q;           // Units still to run.
  logic busy_q;                  // An interval is running.
  logic done_q;                  // End-of-interval pulse.
  logic unit_tick;               // Last cycle of a unit.

  assign unit_tick = busy_q && (pre_q == PRESCALE_W'(UNIT_CYCLES - 1));
  assign tmr.done = done_q;

  // Start loads delay+1 units; cancel wins so no stale pulse appears.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_q <= '0;
      units_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (tmr.cancel) begin
        busy_q <= 1'b0;
      end else if (tmr.start) begin
        pre_q <= '0;
        units_q <= {1'b0, tmr.delay} + 4'h1;
        busy_q <= 1'b1;
      end else if (unit_tick) begin
        pre_q <= '0;
        units_q <= units_q - 4'h1;
        if (units_q == 4'h1) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end else if (busy_q) begin
        pre_q <= pre_q + 1'b1;
      end
    end
  end

  // Helper: cycles since the last start, and the units requested.
  logic [31:0] elapsed_q;
  logic [3:0] want_q;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      elapsed_q <= '0;
      want_q <= '0;
    end else if (tmr.start) begin
      elapsed_q <= 32'h1;
      want_q <= {1'b0, tmr.delay} + 4'h1;
    end else begin
      elapsed_q <= elapsed_q + 32'h1;
    end
  end

  a_retry_interval: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    done_q |-> elapsed_q == 32'(want_q) * 32'(UNIT_CYCLES) + 32'h1)
  else $error("retry interval length wrong");

endmodule

// ---- core/aux_voltage_monitor_fault.sv ----
// Auxiliary voltage monitor: limits, measurement and overvoltage response.
`timescale 1ns/1ps

module aux_voltage_monitor_fault
  import aux_mon_pkg::*;
#(
  parameter int UNIT_CYCLES = RETRY_UNIT_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic write_protect,
  input wire logic clear_faults,
  input wire logic meas_valid,
  input wire logic [15:0] meas_word,
  input wire logic ctrl_pin_on,
  input wire logic operation_on,
  input wire logic other_fault_off,
  output logic cmd_ack_q,
  output logic cmd_nack_q,
  output logic [15:0] cmd_rdata_q,
  output logic alert_line_o_q,
  output logic alert_line_oe_q,
  output logic out_enable_q,
  output logic ov_fault_q,
  output logic ov_warn_q,
  output logic uv_fault_q,
  output logic uv_warn_q
);

  // ----------------------------------------------------------------
  // Registers reached by command code.
  // ----------------------------------------------------------------
  logic [15:0] ov_limit_q;  // Overvoltage fault limit, Linear-11.
  logic [15:0] uv_limit_q;  // Undervoltage fault limit, Linear-11.
  logic [15:0] meas_q;      // Latest measured voltage, Linear-11.
  logic [7:0] ov_resp_q;    // Overvoltage response byte.
  logic cmp_valid_q;        // A new measurement is ready for checking.
  // Decode of the command port; these limits have no page select.
  logic wr_ok, wr_ov_limit, wr_uv_limit, wr_ov_resp, code_known;
  logic [15:0] rd_mux;
  assign wr_ok = cmd_valid && cmd_write && !write_protect;
  assign wr_ov_limit = wr_ok && (cmd_code == CODE_OV_LIMIT);
  assign wr_uv_limit = wr_ok && (cmd_code == CODE_UV_LIMIT);
  assign wr_ov_resp = wr_ok && (cmd_code == CODE_OV_RESP);
  assign code_known = (cmd_code == CODE_OV_LIMIT) || (cmd_code == CODE_UV_LIMIT) ||
    (cmd_code == CODE_MEAS) || (cmd_code == CODE_OV_RESP);
  assign rd_mux = (cmd_code == CODE_OV_LIMIT) ? ov_limit_q :
    (cmd_code == CODE_UV_LIMIT) ? uv_limit_q :
    (cmd_code == CODE_MEAS) ? meas_q :
    (cmd_code == CODE_OV_RESP) ? {8'h00, ov_resp_q} : 16'h0000;

  // Configuration registers; limits store the full two-byte word, the response only its low byte.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ov_limit_q <= OV_LIMIT_RST;
      uv_limit_q <= UV_LIMIT_RST;
      ov_resp_q <= OV_RESP_RST;
    end else begin
      if (wr_ov_limit) begin
        ov_limit_q <= cmd_wdata;
      end
      if (wr_uv_limit) begin
        uv_limit_q <= cmd_wdata;
      end
      if (wr_ov_resp) begin
        ov_resp_q <= cmd_wdata[7:0];
      end
    end
  end

  // Measurement capture; a command write to its code is acknowledged only.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meas_q <= MEAS_RST;
      cmp_valid_q <= 1'b0;
    end else begin
      cmp_valid_q <= meas_valid;
      if (meas_valid) begin
        meas_q <= meas_word;
      end
    end
  end

  // Answer one cycle after each request. Protected writes or unknown codes nack.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_ack_q <= 1'b0;
      cmd_nack_q <= 1'b0;
      cmd_rdata_q <= 16'h0000;
    end else begin
      cmd_ack_q <= cmd_valid && code_known && !(cmd_write && write_protect);
      cmd_nack_q <= cmd_valid && (!code_known || (cmd_write && write_protect));
      if (cmd_valid && !cmd_write) begin
        cmd_rdata_q <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Conversion to fixed point and threshold comparison.
  // ----------------------------------------------------------------
  logic [15:0] lin_word [3];
  logic [FIX_W-1:0] fix_val [3];
  assign lin_word[0] = meas_q;
  assign lin_word[1] = ov_limit_q;
  assign lin_word[2] = uv_limit_q;
  // One converter per word: measurement, OV limit, UV limit.
  generate
    for (genvar gi = 0; gi < 3; gi++) begin : g_conv
      lin11_to_fixed u_conv (
        .word(lin_word[gi]),
        .value(fix_val[gi])
      );
    end
  endgenerate
  // All values carry the same factor, so percentages need no divider.
  logic [CMP_W-1:0] v_x20, ov_x20, ov_x18, ov_x19, uv_x20, uv_x22;
  assign v_x20 = CMP_W'(fix_val[0]) * SCALE_FULL;
  assign ov_x20 = CMP_W'(fix_val[1]) * SCALE_FULL;
  assign ov_x18 = CMP_W'(fix_val[1]) * SCALE_OV_WARN;
  assign ov_x19 = CMP_W'(fix_val[1]) * SCALE_OV_HYST;
  assign uv_x20 = CMP_W'(fix_val[2]) * SCALE_FULL;
  assign uv_x22 = CMP_W'(fix_val[2]) * SCALE_UV_WARN;
  logic ov_trip, ov_warn_hit, uv_trip, uv_warn_hit, below_hyst;
  assign ov_trip = cmp_valid_q && (v_x20 > ov_x20);
  assign ov_warn_hit = cmp_valid_q && (v_x20 > ov_x18);
  assign uv_trip = cmp_valid_q && (v_x20 < uv_x20);
  assign uv_warn_hit = cmp_valid_q && (v_x20 < uv_x22);
  assign below_hyst = cmp_valid_q && (v_x20 < ov_x19);
  // Response fields; 01 behaves as 00 since it is not a defined response.
  logic [1:0] resp_mode;
  logic [2:0] resp_retry;
  logic ov_active;
  assign resp_mode = ov_resp_q[RESP_MODE_LSB+1:RESP_MODE_LSB];
  assign resp_retry = ov_resp_q[RESP_RETRY_LSB+2:RESP_RETRY_LSB];
  // 00 and 01 ignore the fault
  assign ov_active = (resp_mode == MODE_RETRY) || (resp_mode == MODE_HOLD);

  // ----------------------------------------------------------------
  // Status bits and alert line.
  // ----------------------------------------------------------------
  logic ov_fault_d, ov_warn_d, uv_fault_d, uv_warn_d;  // Next values of the status bits.
  assign ov_fault_d = (ov_trip && ov_active) || (ov_fault_q && !clear_faults);
  assign ov_warn_d = ov_warn_hit || (ov_warn_q && !clear_faults);
  assign uv_fault_d = uv_trip || (uv_fault_q && !clear_faults);
  assign uv_warn_d = uv_warn_hit || (uv_warn_q && !clear_faults);

  // The alert line is open drain: only ever driven low.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ov_fault_q <= 1'b0;
      ov_warn_q <= 1'b0;
      uv_fault_q <= 1'b0;
      uv_warn_q <= 1'b0;
      alert_line_o_q <= 1'b0;
      alert_line_oe_q <= 1'b0;
    end else begin
      ov_fault_q <= ov_fault_d;
      ov_warn_q <= ov_warn_d;
      uv_fault_q <= uv_fault_d;
      uv_warn_q <= uv_warn_d;
      alert_line_o_q <= 1'b0;
      // pull alert while any bit stands
      alert_line_oe_q <= ov_fault_d || ov_warn_d || uv_fault_d || uv_warn_d;
    end
  end

  // ----------------------------------------------------------------
  // Run permission: control pin synchronised, others are on-chip logic.
  // ----------------------------------------------------------------
  logic pin_meta_q, pin_sync_q;  // Two-stage synchroniser for the control pin.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= ctrl_pin_on;
      pin_sync_q <= pin_meta_q;
    end
  end

  // commanded off or other fault ends retries
  logic run_ok;
  assign run_ok = pin_sync_q && operation_on && !other_fault_off;

  // ----------------------------------------------------------------
  // Overvoltage response state machine.
  // ----------------------------------------------------------------
  ov_state_e state_q, state_d;
  retry_timer_if tif ();  // Start, cancel and done between the FSM and the timer.
  retry_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_timer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .tmr(tif.timer)
  );

  // Next state. Retry settings 001..110 are undefined and act as no retry.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_ON: begin
        if (ov_trip && ov_active) begin
          if (resp_mode == MODE_HOLD) begin
            state_d = ST_HOLD;
          end else if (resp_retry == RETRY_CONT) begin
            state_d = ST_WAIT_LOW;
          end else begin
            state_d = ST_LATCHED;
          end
        end
      end
      ST_LATCHED: begin
        if (clear_faults) begin
          state_d = ST_ON;
        end
      end
      ST_HOLD: begin
        if (below_hyst) begin
          state_d = ST_ON;
        end
      end
      ST_WAIT_LOW: begin
        // wait for input below 95 percent
        if (below_hyst) begin
          state_d = ST_WAIT_DELAY;
        end
      end
      ST_WAIT_DELAY: begin
        if (tif.done) begin
          state_d = ST_ON;
        end
      end
      default: begin
        state_d = ST_ON;
      end
    endcase
    if (!run_ok) begin
      state_d = ST_ON;
    end
  end

  // interval starts as the wait begins
  assign tif.start = (state_q == ST_WAIT_LOW) && (state_d == ST_WAIT_DELAY);
  assign tif.cancel = !run_ok;
  assign tif.delay = ov_resp_q[2:0];

  // State and output enable; the output runs only when on and allowed.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_ON;
      out_enable_q <= 1'b0;
    end else begin
      state_q <= state_d;
      out_enable_q <= run_ok && (state_d == ST_ON);
    end
  end

  // ----------------------------------------------------------------
  // Checks kept beside the logic.
  // ----------------------------------------------------------------
  a_ov_warn_set: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    cmp_valid_q && (v_x20 > ov_x18) |=> ov_warn_q)
  else $error("OV warning not set above ninety percent");
  a_uv_warn_set: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    cmp_valid_q && (v_x20 < uv_x22) |=> uv_warn_q)
  else $error("UV warning not set below 110 percent");
  a_reset_defaults: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    $past(sys_rst) |-> ov_limit_q == OV_LIMIT_RST && uv_limit_q == UV_LIMIT_RST &&
      ov_resp_q == OV_RESP_RST)
  else $error("limits or response not at reset default");
  a_meas_ro: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    cmd_valid && cmd_write && cmd_code == CODE_MEAS && !meas_valid |=> $stable(meas_q))
  else $error("write changed measured voltage");
  a_ignore_mode: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !ov_active && !ov_fault_q |=> !ov_fault_q)
  else $error("OV fault set while response ignores it");
  a_alert_follows: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    ov_fault_q |-> alert_line_oe_q && !alert_line_o_q)
  else $error("fault bit set without alert pulled low");
  a_disable_now: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    state_q == ST_ON && ov_trip && ov_active |=> !out_enable_q && ov_fault_q)
  else $error("output not disabled on OV fault");
  a_wait_below: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    state_q == ST_WAIT_LOW && !below_hyst |=> state_q != ST_WAIT_DELAY)
  else $error("retry started before input fell below 95 percent");

endmodule

// ---- verif/host_model.sv ----
// Host controller model that issues requests on the monitor's command port.
`timescale 1ns/1ps
module host_model
  import aux_mon_pkg::*;
(
  input wire logic sys_clk,
  input wire logic cmd_ack_q,
  input wire logic cmd_nack_q,
  input wire logic [15:0] cmd_rdata_q,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata
);
  // Idle lines start low; no request before the bench asks for one.
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // One request: raised just after an edge, taken at the next edge, answered after it.
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                      output logic ack, output logic nack, output logic [15:0] rd);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code = code;
    cmd_wdata = data;
    @(posedge sys_clk);
    #1;
    ack = cmd_ack_q;
    nack = cmd_nack_q;
    rd = cmd_rdata_q;
    cmd_valid = 1'b0;
    // Released lines show the inverse, so a stale value is never mistaken for data.
    cmd_code = ~code;
    cmd_wdata = ~data;
    // One idle edge between requests keeps each strobe change in its own time step.
    @(posedge sys_clk);
    #1;
  endtask

  // host parks response
  // An unused monitor input gets a zero response so its overvoltage faults are ignored.
  task automatic park_unused(output logic ack);
    logic n;
    logic [15:0] d;
    xfer(1'b1, CODE_OV_RESP, 16'h0000, ack, n, d);
  endtask
endmodule

// ---- verif/test_aux_voltage_monitor_fault.sv ----
// Self-checking bench for the auxiliary voltage monitor.
`timescale 1ns/1ps
module test_aux_voltage_monitor_fault;
  import aux_mon_pkg::*;
  // Short retry unit keeps every retry wait to a few dozen cycles.
  localparam int UNIT = 10;
  logic sys_clk, sys_rst, write_protect, clear_faults, meas_valid;
  logic ctrl_pin_on, operation_on, other_fault_off;
  logic [15:0] meas_word;
  logic cmd_valid, cmd_write, cmd_ack_q, cmd_nack_q;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata_q;
  logic alert_line_o_q, alert_line_oe_q, out_enable_q;
  logic ov_fault_q, ov_warn_q, uv_fault_q, uv_warn_q;
  int err_count = 0;
  int checks = 0;
  // Packed status: alert level, enable, OV fault, OV warn, UV fault, UV warn, alert.
  wire logic [15:0] st = {9'h000, alert_line_o_q, out_enable_q, ov_fault_q, ov_warn_q,
                          uv_fault_q, uv_warn_q, alert_line_oe_q};

  aux_voltage_monitor_fault #(.UNIT_CYCLES(UNIT)) aux_voltage_monitor_fault_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .write_protect(write_protect),
    .clear_faults(clear_faults), .meas_valid(meas_valid), .meas_word(meas_word),
    .ctrl_pin_on(ctrl_pin_on), .operation_on(operation_on),
    .other_fault_off(other_fault_off), .cmd_ack_q(cmd_ack_q), .cmd_nack_q(cmd_nack_q),
    .cmd_rdata_q(cmd_rdata_q), .alert_line_o_q(alert_line_o_q),
    .alert_line_oe_q(alert_line_oe_q), .out_enable_q(out_enable_q),
    .ov_fault_q(ov_fault_q), .ov_warn_q(ov_warn_q), .uv_fault_q(uv_fault_q),
    .uv_warn_q(uv_warn_q));

  host_model host_model_inst (
    .sys_clk(sys_clk), .cmd_ack_q(cmd_ack_q), .cmd_nack_q(cmd_nack_q),
    .cmd_rdata_q(cmd_rdata_q), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

  // ----------------------------------------------------------------
  // Shared helpers.
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Every drive lands 1 ns after a rising edge.
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] code, input logic [15:0] exp, input logic ok);
    logic a, n;
    logic [15:0] d;
    host_model_inst.xfer(1'b0, code, 16'h0000, a, n, d);
    chk("read_ack", {15'h0000, a}, {15'h0000, ok});
    if (ok) chk("read_data", d, exp);
  endtask

  task automatic wr(input logic [7:0] code, input logic [15:0] data, input logic ok);
    logic a, n;
    logic [15:0] d;
    host_model_inst.xfer(1'b1, code, data, a, n, d);
    chk("write_ack", {15'h0000, a}, {15'h0000, ok});
    chk("write_nack", {15'h0000, n}, {15'h0000, ~ok});
  endtask

  // Measurement with exponent -8; status is settled one edge after the take.
  task automatic meas(input logic [10:0] m);
    meas_word = {5'b11000, m};
    meas_valid = 1'b1;
    tick(1);
    meas_valid = 1'b0;
    tick(1);
  endtask

  task automatic clear;
    meas(11'h100);
    clear_faults = 1'b1;
    tick(1);
    clear_faults = 1'b0;
    tick(2);
  endtask

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task automatic t_reset;
    tick(1);
    chk("reset_outputs", st, 16'h0000);
    tick(3);
    chk("enabled", st, 16'h0020);
    $display("test reset done");
  endtask

  task automatic t_regs;
    rd(CODE_OV_LIMIT, 16'hc266, 1'b1);
    rd(CODE_UV_LIMIT, 16'hb0cc, 1'b1);
    rd(CODE_OV_RESP, 16'h00bf, 1'b1);
    rd(CODE_MEAS, 16'h0000, 1'b1);
    wr(CODE_MEAS, 16'h1234, 1'b1);
    rd(CODE_MEAS, 16'h0000, 1'b1);
    rd(8'hf9, 16'h0000, 1'b0);
    write_protect = 1'b1;
    wr(CODE_OV_LIMIT, 16'h0001, 1'b0);
    write_protect = 1'b0;
    rd(CODE_OV_LIMIT, 16'hc266, 1'b1);
    wr(CODE_UV_LIMIT, 16'hb0cd, 1'b1);
    rd(CODE_UV_LIMIT, 16'hb0cd, 1'b1);
    wr(CODE_UV_LIMIT, 16'hb0cc, 1'b1);
    $display("test registers done");
  endtask

  // Limits in exponent -8 counts: OV 614, warn 552.6, UV 51, UV warn 56.1.
  task automatic t_warn;
    meas(11'h230);
    chk("ov_warn", st, 16'h0029);
    clear();
    chk("cleared", st, 16'h0020);
    meas(11'h035);
    chk("uv_warn", st, 16'h0023);
    meas(11'h020);
    chk("uv_fault", st, 16'h0027);
    clear();
    $display("test warnings done");
  endtask

  task automatic t_ignore;
    logic a;
    host_model_inst.park_unused(a);
    chk("park_ack", {15'h0000, a}, 16'h0001);
    meas(11'h280);
    chk("ignored", st, 16'h0029);
    clear();
    wr(CODE_OV_RESP, 16'h007f, 1'b1);
    meas(11'h280);
    chk("unused_mode", st, 16'h0029);
    clear();
    $display("test ignore done");
  endtask

  // Delay codes 0 and 7; the first restart is cut by the pin, the second by a fault.
  task automatic t_retry;
    int n;
    for (int d = 0; d < 8; d += 7) begin
      wr(CODE_OV_RESP, 16'h00b8 | 16'(d), 1'b1);
      meas(11'h280);
      chk("retry_off", st, 16'h0019);
      tick(30);
      chk("retry_wait", st, 16'h0019);
      meas(11'h200);
      n = 0;
      while (out_enable_q !== 1'b1 && n < 200) begin
        tick(1);
        n++;
      end
      chk("retry_gap", 16'(n >= (d + 1) * UNIT && n <= (d + 1) * UNIT + 3), 16'h0001);
      if (d == 0) ctrl_pin_on = 1'b0;
      else other_fault_off = 1'b1;
      tick(4);
      chk("commanded_off", st, 16'h0019);
      ctrl_pin_on = 1'b1;
      other_fault_off = 1'b0;
      clear();
    end
    $display("test retry done");
  endtask

  task automatic t_latch;
    for (int i = 0; i < 2; i++) begin
      wr(CODE_OV_RESP, i ? 16'h0098 : 16'h0080, 1'b1);
      meas(11'h280);
      meas(11'h200);
      tick(40);
      chk("latched", st, 16'h0019);
      clear();
      chk("released", st, 16'h0020);
    end
    wr(CODE_OV_RESP, 16'h00c0, 1'b1);
    meas(11'h280);
    meas(11'h258);
    chk("hold_off", st, 16'h0019);
    operation_on = 1'b0;
    meas(11'h200);
    chk("hold_cmd_off", st, 16'h0019);
    operation_on = 1'b1;
    tick(2);
    chk("hold_resume", st, 16'h0039);
    meas(11'h280);
    meas(11'h200);
    chk("hold_below", st, 16'h0039);
    $display("test latch and hold done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Free-running 125 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // The whole run needs about 400 cycles; the watchdog allows far more.
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    results();
  end

  initial begin
    sys_rst = 1'b1;
    write_protect = 1'b0;
    clear_faults = 1'b0;
    meas_valid = 1'b0;
    meas_word = 16'h0000;
    ctrl_pin_on = 1'b1;
    operation_on = 1'b1;
    other_fault_off = 1'b0;
    repeat (12) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    t_reset();
    t_regs();
    t_warn();
    t_ignore();
    t_retry();
    t_latch();
    results();
  end
endmodule
